/* pbs_sram.sv */
// Overview of operation
// - Array of 131072 words, 36 bits, four 9-bit byte lanes a to d.
// - Address, data and controls except output enable and order are clock-registered.
// - Read data passes an output register, one cycle pipeline latency.
// - Controller strobe abandons burst, loads address, starts read, write or deselect.
// - Processor strobe loads address and starts only read or deselect.
// - Primary enable high ignores processor strobe; controller strobe then deselects.
// - Depth enables inactive at a strobe deselect; data pins stay undriven.
// - Read from deselect needs all enables and a read-qualified strobe.
// - Without strobes, advance low steps burst address, high holds it.
// - Two-bit counter acts only on the low address bits.
// - Linear order increments low bits modulo four.
// - Interleaved order XORs start bits with count zero to three.
// - Burst order select is unregistered and static; low linear, high interleaved.
// - Output enable acts asynchronously; high releases the data pins.
// - Global write low writes all four bytes, except in a processor strobe cycle, which reads.
// - Write enable low writes lanes with byte write low; otherwise read.
// - Each byte write input controls exactly its own lane.
// - Write is stored in the array at the edge after the sampling edge.
// - Chip enables matter only in cycles with an address strobe.
`timescale 1ns/1ps
`default_nettype none

module pbs_sram
    import pbs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Address and strobes
    input wire logic [ADDR_W-1:0] addr_in_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic burst_order_select_i,
    // Chip enables
    input wire logic primary_chip_enable_n_i,
    input wire logic depth_enable_hi_i,
    input wire logic depth_enable_lo_n_i,
    // Write controls
    input wire logic global_write_n_i,
    input wire logic write_enable_n_i,
    input wire logic [LANES-1:0] byte_write_n_i,
    // Output enable
    input wire logic output_enable_n_i,
    // Data pins
    input wire logic [DATA_W-1:0] data_lane_i,
    output logic [DATA_W-1:0] data_lane_o,
    output logic data_lane_oe_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] q_addr;
    logic q_ctrl_n;
    logic q_proc_n;
    logic q_adv_n;
    logic q_se_pri_n;
    logic q_se_hi;
    logic q_se_lo_n;
    logic q_gw_n;
    logic q_we_n;
    logic [LANES-1:0] q_bw_n;
    logic [DATA_W-1:0] q_data;

    logic [DATA_W-1:0] mem [WORDS];

    pbs_cycle_t op_state;
    pbs_cycle_t cur_op;
    logic chip_en;
    logic proc_start;
    logic ctrl_start;
    logic start;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] cyc_addr;
    logic rd_valid;
    logic [DATA_W-1:0] rd_word;

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    // controls captured at the rising edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q_ctrl_n <= STROBE_IDLE;
            q_proc_n <= STROBE_IDLE;
            q_adv_n <= STROBE_IDLE;
            q_se_pri_n <= STROBE_IDLE;
            q_se_hi <= 1'h0;
            q_se_lo_n <= STROBE_IDLE;
            q_gw_n <= STROBE_IDLE;
            q_we_n <= STROBE_IDLE;
            q_bw_n <= BYTE_WRITE_RST;
        end
        else
        begin
            q_ctrl_n <= controller_addr_strobe_n_i;
            q_proc_n <= processor_addr_strobe_n_i;
            q_adv_n <= burst_advance_n_i;
            q_se_pri_n <= primary_chip_enable_n_i;
            q_se_hi <= depth_enable_hi_i;
            q_se_lo_n <= depth_enable_lo_n_i;
            q_gw_n <= global_write_n_i;
            q_we_n <= write_enable_n_i;
            q_bw_n <= byte_write_n_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q_addr <= ADDR_RST;
            q_data <= DATA_RST;
        end
        else
        begin
            q_addr <= addr_in_i;
            q_data <= data_lane_i;
        end
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    always_comb
    begin
        chip_en = !q_se_pri_n && q_se_hi && !q_se_lo_n;
        lanes = pbs_lane_mask(q_gw_n, q_we_n, q_bw_n);
        // processor strobe blocked by primary enable
        proc_start = !q_proc_n && !q_se_pri_n;
        ctrl_start = !q_ctrl_n;
        start = proc_start || ctrl_start;
        cur_op = PBS_DESEL;
        // enables only looked at on a strobe
        if (start)
        begin
            if (!chip_en)
            begin
                cur_op = PBS_DESEL;
            end
            else if (proc_start)
            begin
                cur_op = PBS_READ;
            end
            else if (lanes != LANES_NONE)
            begin
                cur_op = PBS_WRITE;
            end
            else
            begin
                cur_op = PBS_READ;
            end
        end
        else if (op_state != PBS_DESEL)
        begin
            cur_op = (lanes != LANES_NONE) ? PBS_WRITE : PBS_READ;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            op_state <= PBS_DESEL;
        end
        else
        begin
            op_state <= cur_op;
        end
    end

    // ------------------------------------------------------------
    // Burst address generation
    // ------------------------------------------------------------
    // order select used as static configuration
    pbs_burst_ctr u_burst (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .load_i(start),
        .advance_i(!q_adv_n),
        .order_i(burst_order_select_i),
        .ext_addr_i(q_addr),
        .cyc_addr_o(cyc_addr)
    );

    // ------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------
    assign rd_word = mem[cyc_addr];

    // self-timed write at the next edge
    always_ff @(posedge clk_sys_i)
    begin
        if (cur_op == PBS_WRITE)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (lanes[i])
                begin
                    mem[cyc_addr][i*LANE_W +: LANE_W] <= q_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output register and drivers
    // ------------------------------------------------------------
    // pipelined read register
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            data_lane_o <= DATA_RST;
            rd_valid <= 1'h0;
        end
        else
        begin
            rd_valid <= (cur_op == PBS_READ);
            if (cur_op == PBS_READ)
            begin
                data_lane_o <= rd_word;
            end
        end
    end

    assign data_lane_oe_o = rd_valid && !output_enable_n_i;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking

    default disable iff (!rst_b_i);

    logic adv_cyc;
    assign adv_cyc = !start && !q_adv_n;

    property p_read_latency;
        (cur_op == PBS_READ) |=> rd_valid && (data_lane_o === $past(rd_word));
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read data not registered one cycle later");

    property p_proc_no_write;
        proc_start |-> (cur_op != PBS_WRITE);
    endproperty
    a_proc_no_write: assert property (p_proc_no_write)
        else $error("processor strobe began a write");

    property p_pri_deselect;
        (q_se_pri_n && !q_ctrl_n) |=> !rd_valid ##0 !data_lane_oe_o;
    endproperty
    a_pri_deselect: assert property (p_pri_deselect)
        else $error("primary enable high did not deselect");

    property p_depth_deselect;
        (start && (!q_se_hi || q_se_lo_n)) |-> (cur_op == PBS_DESEL) ##1 !data_lane_oe_o;
    endproperty
    a_depth_deselect: assert property (p_depth_deselect)
        else $error("depth enables inactive but device selected");

    property p_global_write;
        (!q_gw_n && ctrl_start && !proc_start && chip_en) |-> (cur_op == PBS_WRITE)
            && (lanes == LANES_ALL);
    endproperty
    a_global_write: assert property (p_global_write)
        else $error("global write did not write all lanes");

    property p_no_write_inputs;
        (q_gw_n && (q_we_n || (q_bw_n == BYTE_WRITE_RST))) |-> (cur_op != PBS_WRITE);
    endproperty
    a_no_write_inputs: assert property (p_no_write_inputs)
        else $error("write without active write inputs");

    property p_hold;
        (!start && q_adv_n) |-> $stable(cyc_addr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("burst address moved while suspended");

    property p_upper_fixed;
        !start |-> (cyc_addr[ADDR_W-1:BURST_W] == $past(cyc_addr[ADDR_W-1:BURST_W]));
    endproperty
    a_upper_fixed: assert property (p_upper_fixed)
        else $error("upper address bits changed during burst");

    property p_linear_step;
        (burst_order_select_i == ORDER_LINEAR) && adv_cyc |->
            (cyc_addr[BURST_W-1:0] == 2'($past(cyc_addr[BURST_W-1:0]) + CNT_STEP));
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("linear burst did not increment");

    property p_interleave_step;
        (burst_order_select_i == ORDER_INTERLEAVED) && start ##1 adv_cyc |->
            (cyc_addr[BURST_W-1:0] == ($past(cyc_addr[BURST_W-1:0]) ^ CNT_STEP));
    endproperty
    a_interleave_step: assert property (p_interleave_step)
        else $error("interleaved second address wrong");

    property p_wrap;
        start ##1 adv_cyc [*4] |-> (cyc_addr == $past(cyc_addr, 4));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst left its four word group");

    property p_write_done;
        (cur_op == PBS_WRITE) && (lanes == LANES_ALL) |=>
            (mem[$past(cyc_addr)] == $past(q_data));
    endproperty
    a_write_done: assert property (p_write_done)
        else $error("write data not stored");

    property p_oe_release;
        output_enable_n_i |-> !data_lane_oe_o;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("pins driven with output enable high");

    c_read_burst: cover property (start && cur_op == PBS_READ ##1 adv_cyc [*3]);
    c_write_burst: cover property (cur_op == PBS_WRITE && start ##1 cur_op == PBS_WRITE);
    c_deselect: cover property (op_state == PBS_READ && cur_op == PBS_DESEL);
    c_byte_write: cover property (cur_op == PBS_WRITE && lanes != LANES_ALL);

endmodule

`default_nettype wire

/* pbs_pkg.sv */
`default_nettype none

package pbs_pkg;

    // ------------------------------------------------------------
    // Array organisation
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int WORDS = 131072;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int BURST_W = 2;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic ORDER_LINEAR = 1'h0;
    localparam logic ORDER_INTERLEAVED = 1'h1;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] BYTE_WRITE_RST = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;
    localparam logic STROBE_IDLE = 1'h1;

    typedef enum logic [1:0] {
        PBS_DESEL = 2'b00,
        PBS_READ = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_cycle_t;

    // ------------------------------------------------------------
    // Burst sequence: low address bits for a given count
    // ------------------------------------------------------------
    function automatic logic [BURST_W-1:0] pbs_burst_low(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] cnt,
        input logic order
    );
        logic [BURST_W-1:0] sum;
        sum = start + cnt;
        if (order == ORDER_INTERLEAVED)
        begin
            return start ^ cnt;
        end
        return sum;
    endfunction

    // ------------------------------------------------------------
    // Write lane decode from global, enable and byte writes
    // ------------------------------------------------------------
    function automatic logic [LANES-1:0] pbs_lane_mask(
        input logic global_n,
        input logic enable_n,
        input logic [LANES-1:0] byte_n
    );
        if (!global_n)
        begin
            return LANES_ALL;
        end
        if (!enable_n)
        begin
            return ~byte_n;
        end
        return LANES_NONE;
    endfunction

endpackage

`default_nettype wire

/* pbs_burst_ctr.sv */
`timescale 1ns/1ps
`default_nettype none

module pbs_burst_ctr
    import pbs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Control
    input wire logic load_i,
    input wire logic advance_i,
    input wire logic order_i,
    // Address
    input wire logic [ADDR_W-1:0] ext_addr_i,
    output logic [ADDR_W-1:0] cyc_addr_o
);

    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] cnt;
    logic [BURST_W-1:0] next_cnt;

    // ------------------------------------------------------------
    // Count: cleared on load, stepped on advance, held otherwise
    // ------------------------------------------------------------
    always_comb
    begin
        next_cnt = cnt;
        if (load_i)
        begin
            next_cnt = CNT_RST;
        end
        else if (advance_i)
        begin
            next_cnt = cnt + CNT_STEP;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt <= CNT_RST;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            base <= ADDR_RST;
        end
        else if (load_i)
        begin
            base <= ext_addr_i;
        end
    end

    // ------------------------------------------------------------
    // Address used by the current cycle
    // ------------------------------------------------------------
    // counter acts on low bits only
    assign cyc_addr_o = load_i ? ext_addr_i :
        {base[ADDR_W-1:BURST_W], pbs_burst_low(base[BURST_W-1:0], next_cnt, order_i)};

endmodule

`default_nettype wire

/* pbs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pbs_host_model
    import pbs_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Memory bus pins
    output var logic [ADDR_W-1:0] addr_in_o,
    output var logic controller_addr_strobe_n_o,
    output var logic processor_addr_strobe_n_o,
    output var logic burst_advance_n_o,
    output var logic primary_chip_enable_n_o,
    output var logic depth_enable_hi_o,
    output var logic depth_enable_lo_n_o,
    output var logic global_write_n_o,
    output var logic write_enable_n_o,
    output var logic [LANES-1:0] byte_write_n_o,
    output var logic output_enable_n_o,
    output var logic [DATA_W-1:0] data_lane_o
);
    logic wr_prev;

    initial
    begin
        wr_prev = 1'b0;
        {controller_addr_strobe_n_o, processor_addr_strobe_n_o, burst_advance_n_o} = 3'h7;
        {primary_chip_enable_n_o, depth_enable_hi_o, depth_enable_lo_n_o} = 3'h5;
        {global_write_n_o, write_enable_n_o, byte_write_n_o} = 6'h3F;
        output_enable_n_o = 1'b0;
        addr_in_o = ADDR_RST;
        data_lane_o = DATA_RST;
    end

    // One bus cycle, launched after a falling edge
    task automatic op(input logic cs_n, ps_n, adv_n, input logic [2:0] en,
            input logic gw_n, we_n, input logic [LANES-1:0] bw_n,
            input logic [ADDR_W-1:0] a);
        logic wr;
        wr = !gw_n || (!we_n && bw_n != 4'hF);
        @(negedge clk_sys_i);
        controller_addr_strobe_n_o = cs_n;
        processor_addr_strobe_n_o = ps_n;
        burst_advance_n_o = adv_n;
        {primary_chip_enable_n_o, depth_enable_hi_o, depth_enable_lo_n_o} = en;
        global_write_n_o = gw_n;
        write_enable_n_o = we_n;
        byte_write_n_o = bw_n;
        addr_in_o = a;
        output_enable_n_o = wr || wr_prev;
        wr_prev = wr;
        // Data lines take a new random value every cycle, write cycles included
        data_lane_o = DATA_W'({$urandom(), $urandom()});
    endtask
endmodule

`default_nettype wire

/* pbs_sram_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pbs_sram_tb
    import pbs_pkg::*;
;
    localparam logic [2:0] EN_ON = 3'h2;
    localparam logic [ADDR_W-1:0] A0 = 17'h00100;
    localparam logic [LANES-1:0] BW_OFF = 4'hF;
    logic clk_sys_i, rst_b_i, burst_order_select_i, output_enable_n_i;
    logic controller_addr_strobe_n_i, processor_addr_strobe_n_i, burst_advance_n_i;
    logic primary_chip_enable_n_i, depth_enable_hi_i, depth_enable_lo_n_i;
    logic global_write_n_i, write_enable_n_i, data_lane_oe_o;
    logic [LANES-1:0] byte_write_n_i, r_ln;
    logic [ADDR_W-1:0] addr_in_i, r_addr, base, ma;
    logic [DATA_W-1:0] data_lane_i, data_lane_o, r_data, exp_d, w;
    logic [DATA_W-1:0] mem [int];
    logic [1:0] cnt, lo;
    logic r_cs, r_ps, r_adv, r_pce, r_ehi, r_elo, exp_rv;
    int st, typ, errors, total_checks;
    int cycles = 0;

    pbs_sram i_pbs_sram (.clk_sys_i, .rst_b_i, .addr_in_i, .controller_addr_strobe_n_i,
        .processor_addr_strobe_n_i, .burst_advance_n_i, .burst_order_select_i,
        .primary_chip_enable_n_i, .depth_enable_hi_i, .depth_enable_lo_n_i,
        .global_write_n_i, .write_enable_n_i, .byte_write_n_i, .output_enable_n_i,
        .data_lane_i, .data_lane_o, .data_lane_oe_o);

    pbs_host_model i_pbs_host_model (.clk_sys_i, .addr_in_o(addr_in_i),
        .controller_addr_strobe_n_o(controller_addr_strobe_n_i),
        .processor_addr_strobe_n_o(processor_addr_strobe_n_i),
        .burst_advance_n_o(burst_advance_n_i),
        .primary_chip_enable_n_o(primary_chip_enable_n_i),
        .depth_enable_hi_o(depth_enable_hi_i), .depth_enable_lo_n_o(depth_enable_lo_n_i),
        .global_write_n_o(global_write_n_i), .write_enable_n_o(write_enable_n_i),
        .byte_write_n_o(byte_write_n_i), .output_enable_n_o(output_enable_n_i),
        .data_lane_o(data_lane_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------
    // Reference model, one edge behind the sampling edge
    // ------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st = 0;
            exp_rv = 1'b0;
            {r_cs, r_ps, r_pce} = 3'h7;
        end
        else
        begin
            if (!r_cs || (!r_ps && !r_pce))
            begin
                base = r_addr;
                cnt = 2'h0;
                typ = (r_pce || !r_ehi || r_elo) ? 0 : (!r_ps || r_ln == 4'h0) ? 1 : 2;
            end
            else if (st != 0)
            begin
                cnt = cnt + {1'b0, !r_adv};
                typ = (r_ln == 4'h0) ? 1 : 2;
            end
            else
                typ = 0;
            lo = burst_order_select_i ? base[1:0] ^ cnt : base[1:0] + cnt;
            ma = {base[ADDR_W-1:2], lo};
            w = (typ != 0 && mem.exists(ma)) ? mem[ma] : 'x;
            for (int l = 0; l < LANES; l++)
                if (typ == 2 && r_ln[l]) w[l*LANE_W +: LANE_W] = r_data[l*LANE_W +: LANE_W];
            if (typ == 2) mem[ma] = w;
            exp_rv = (typ == 1);
            if (exp_rv) exp_d = w;
            st = typ;
            {r_cs, r_ps, r_adv} = {controller_addr_strobe_n_i, processor_addr_strobe_n_i,
                burst_advance_n_i};
            {r_pce, r_ehi, r_elo} = {primary_chip_enable_n_i, depth_enable_hi_i,
                depth_enable_lo_n_i};
            r_addr = addr_in_i;
            r_data = data_lane_i;
            r_ln = !global_write_n_i ? LANES_ALL :
                !write_enable_n_i ? ~byte_write_n_i : LANES_NONE;
        end
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always
    begin
        @(posedge clk_sys_i);
        #5;
        if (rst_b_i === 1'b1)
        begin
            check(DATA_W'(data_lane_oe_o), DATA_W'(exp_rv && !output_enable_n_i));
            if (exp_rv) check(data_lane_o, exp_d);
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            summarize();
        end
    end

    function automatic logic [2:0] rnd_en();
        return ($urandom % 3 != 0) ? EN_ON : 3'($urandom);
    endfunction

    function automatic logic [ADDR_W-1:0] rnd_a();
        return {13'h0010, 4'($urandom)};
    endfunction

    task automatic go(input logic cs, ps, burst_advance_n, input logic [2:0] en, input logic gw, we,
            input logic [LANES-1:0] bw, input logic [ADDR_W-1:0] a);
        i_pbs_host_model.op(cs, ps, burst_advance_n, en, gw, we, bw, a);
    endtask

    task automatic rd(input logic burst_advance_n);
        go(1, 1, burst_advance_n, rnd_en(), 1, 1, BW_OFF, rnd_a());
    endtask

    task automatic done(input string name);
        $display("test %s ended, mismatches so far %0d", name, errors);
    endtask

    initial
    begin
        clk_sys_i = 1'b0;
        rst_b_i = 1'b0;
        burst_order_select_i = ORDER_LINEAR;
        errors = 0;
        total_checks = 0;
        void'($urandom(78542));
        repeat (2) @(posedge clk_sys_i);
        #5;
        check(data_lane_o, DATA_RST);
        check(DATA_W'(data_lane_oe_o), DATA_RST);
        @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        go(0, 1, 1, 3'h5, 1, 1, BW_OFF, A0);
        go(0, 1, 1, EN_ON, 0, 1, BW_OFF, A0);
        repeat (3) go(1, 1, 0, rnd_en(), 0, 1, BW_OFF, rnd_a());
        done("global write burst");
        go(0, 1, 1, EN_ON, 1, 1, BW_OFF, A0 + 17'h1);
        repeat (3) rd(0);
        rd(1);
        rd(0);
        go(0, 1, 1, EN_ON, 1, 1, BW_OFF, A0 + 17'h2);
        rd(0);
        done("read burst wrap and restart");
        for (int l = 0; l < LANES; l++) go(0, 1, 1, EN_ON, 1, 0, ~(4'h1 << l), A0 + 17'(l));
        go(0, 1, 1, EN_ON, 1, 0, BW_OFF, A0);
        go(0, 1, 1, EN_ON, 1, 1, 4'h0, A0 + 17'h1);
        repeat (3) rd(0);
        done("byte lanes");
        go(1, 0, 1, EN_ON, 0, 1, BW_OFF, A0 + 17'h3);
        go(0, 0, 1, EN_ON, 0, 0, 4'h0, A0);
        rd(0);
        go(1, 0, 0, 3'h6, 1, 1, BW_OFF, A0);
        go(0, 1, 1, 3'h6, 1, 1, BW_OFF, A0);
        go(1, 0, 1, 3'h0, 1, 1, BW_OFF, A0);
        go(0, 1, 1, 3'h3, 1, 1, BW_OFF, A0);
        rd(0);
        done("strobes and enables");
        burst_order_select_i = ORDER_INTERLEAVED;
        go(1, 0, 1, EN_ON, 1, 1, BW_OFF, A0 + 17'h1);
        repeat (4) rd(0);
        rd(1);
        @(negedge clk_sys_i);
        check(DATA_W'(data_lane_oe_o), DATA_W'(1));
        i_pbs_host_model.output_enable_n_o = 1'b1;
        #1;
        check(DATA_W'(data_lane_oe_o), DATA_RST);
        go(0, 1, 1, 3'h6, 1, 1, BW_OFF, A0);
        burst_order_select_i = ORDER_LINEAR;
        done("interleaved and output enable");
        repeat (300) go($urandom % 3 != 0, $urandom % 4 != 0, 1'($urandom), rnd_en(),
            $urandom % 4 != 0, 1'($urandom), 4'($urandom), rnd_a());
        go(0, 1, 1, 3'h6, 1, 1, BW_OFF, A0);
        repeat (3) @(posedge clk_sys_i);
        done("random traffic");
        summarize();
    end
endmodule

`default_nettype wire
